// >>> sncr_host.sv
// host controller end: ahb-lite slave that issues link requests
`timescale 1ns/1ps
module sncr_host
    import sncr_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    sncr_link_if.host link
);
    // ==========================================
    // state
    typedef struct packed {
        logic dataPhase;
        logic dWrite;
        logic [31:0] dAddr;
        logic [31:0] wdata;
        logic [31:0] rdata;
        logic pending;
        logic reqValid;
        logic reqWrite;
        logic [7:0] reqAddr;
        logic [31:0] reqData;
        logic frame;
        logic [31:0] hrdata;
    } sncr_host_t;

    sncr_host_t state_reg;
    sncr_host_t state_next;
    logic [1:0] op;

    always_comb begin
        state_next = state_reg;
        op = 2'h0;
        state_next.reqValid = 1'b0;
        state_next.frame = 1'b0;
        if (link.rspValid) begin
            state_next.rdata = link.rspData;
            state_next.pending = 1'b0;
        end
        // ==========================================
        // data phase of the previous address phase
        if (state_reg.dataPhase && state_reg.dWrite) begin
            unique case (state_reg.dAddr)
                H_WDATA_OFS: state_next.wdata = hwdata;
                H_CMD_OFS: begin
                    // cmd word: [9:8] op, [7:0] node register offset
                    op = hwdata[9:8];
                    // orders are dropped while the node programs its memory
                    if (!link.busy) begin // RQ12
                        state_next.reqAddr = hwdata[7:0];
                        state_next.reqData = state_reg.wdata;
                        if (op == 2'(SNCR_WR) || op == 2'(SNCR_RD)) begin
                            state_next.reqValid = 1'b1;
                            state_next.reqWrite = op == 2'(SNCR_WR);
                            state_next.pending = op == 2'(SNCR_RD);
                        end else if (op == 2'(SNCR_FRAME)) begin
                            state_next.frame = 1'b1;
                        end
                    end
                end
                default: ;
            endcase
        end
        state_next.hrdata = 32'h0;
        if (hsel && hready && htrans[1] && !hwrite) begin
            unique case (haddr)
                H_STAT_OFS: state_next.hrdata = {30'h0, state_reg.pending, link.busy};
                H_RDATA_OFS: state_next.hrdata = state_reg.rdata;
                H_WDATA_OFS: state_next.hrdata = state_reg.wdata;
                default: state_next.hrdata = 32'h0;
            endcase
        end
        state_next.dataPhase = hsel && hready && htrans[1];
        state_next.dWrite = hwrite;
        state_next.dAddr = haddr;
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign hrdata = state_reg.hrdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign link.reqValid = state_reg.reqValid;
    assign link.reqWrite = state_reg.reqWrite;
    assign link.reqAddr = state_reg.reqAddr;
    assign link.reqData = state_reg.reqData;
    // host writes carry reserved bits as the software gave them; software keeps them zero
    assign link.frameStrobe = state_reg.frame; // RQ20
    assign link.frameAddr = state_reg.reqData[4:0];
    assign link.frameGroup = state_reg.reqData[15:8];
    assign link.frameIsGroup = state_reg.reqData[16];
endmodule : sncr_host

// >>> sncr_link_if.sv
// link between host controller and stack node register bank
`timescale 1ns/1ps
interface sncr_link_if;
    logic reqValid;
    logic reqWrite;
    logic [7:0] reqAddr;
    logic [31:0] reqData;
    logic frameStrobe;
    logic [4:0] frameAddr;
    logic [7:0] frameGroup;
    logic frameIsGroup;
    logic rspValid;
    logic [31:0] rspData;
    logic busy;
    modport node (input reqValid, reqWrite, reqAddr, reqData, frameStrobe, frameAddr,
        frameGroup, frameIsGroup, output rspValid, rspData, busy);
    modport host (output reqValid, reqWrite, reqAddr, reqData, frameStrobe, frameAddr,
        frameGroup, frameIsGroup, input rspValid, rspData, busy);
endinterface : sncr_link_if

// >>> sncr_link_properties.sv
// concurrent checks on the host to node link
`timescale 1ns/1ps
module sncr_link_properties
    import sncr_pkg::*;
#(
    parameter int SAVE_LEN = SAVE_CYCLES
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic reqValid,
    input wire logic reqWrite,
    input wire logic [7:0] reqAddr,
    input wire logic [31:0] reqData,
    input wire logic rspValid,
    input wire logic [31:0] rspData,
    input wire logic busy
);
    // ==========================================
    // shadow state: writes refused while busy are left out
    logic wrOk;
    logic restart;
    logic [7:0] rdAddr_reg;
    logic [4:0] count_reg;
    logic [3:0] tag_reg;
    logic keyA_reg;
    logic keyB_reg;
    int busyCnt_reg;
    assign wrOk = reqValid && reqWrite && !busy;
    assign restart = wrOk && reqAddr == CTRL_OFS && reqData[RESTART_BIT];
    always_ff @(posedge ref_clk) begin
        if (rst || restart) begin
            count_reg <= CHAN_RESET;
            tag_reg <= 4'h0;
            keyA_reg <= 1'b0;
            keyB_reg <= 1'b0;
        end else if (wrOk) begin
            if (reqAddr == CELL_CHANNEL_COUNT_REG_OFS) count_reg <= reqData[4:0];
            if (reqAddr == GROUP_OFS) tag_reg <= reqData[3:0];
            if (reqAddr == KEYA_OFS) keyA_reg <= reqData == UNLOCK_KEY_A;
            if (reqAddr == KEYB_OFS) keyB_reg <= reqData == UNLOCK_KEY_B;
        end
    end
    always_ff @(posedge ref_clk) begin
        if (reqValid && !reqWrite) rdAddr_reg <= reqAddr;
        busyCnt_reg <= (rst || !busy) ? 0 : busyCnt_reg + 1;
    end
    // ==========================================
    // properties
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    a_read_answer: assert property (reqValid && !reqWrite && !busy |=> rspValid)
        else $error("read got no answer");
    a_busy_drops: assert property (busy |=> !rspValid)
        else $error("read answered while busy");
    a_no_req_busy: assert property (busy && $past(busy) |-> !reqValid)
        else $error("request issued while busy");
    a_count_readback: assert property (rspValid && rdAddr_reg == CELL_CHANNEL_COUNT_REG_OFS
        |-> rspData[7:0] == {3'h0, count_reg}) else $error("count readback wrong");
    a_group_readback: assert property (rspValid && rdAddr_reg == GROUP_OFS
        |-> rspData[3:0] == tag_reg) else $error("group tag readback wrong");
    a_group_upper_zero: assert property (rspValid && rdAddr_reg == GROUP_OFS
        |-> rspData[7:4] == 4'h0) else $error("group upper nibble set");
    a_restart_reads_zero: assert property (rspValid && rdAddr_reg == CTRL_OFS
        |-> !rspData[RESTART_BIT] && rspData[2:0] == 3'h0) else $error("control read bad");
    a_reserved_zero: assert property (rspValid && rdAddr_reg == ADDR_OFS
        |-> rspData[7:5] == 3'h0) else $error("address reserved bits set");
    a_save_keys: assert property ($rose(busy) |-> $past(keyA_reg && keyB_reg && wrOk
        && reqAddr == CTRL_OFS && reqData[SAVE_BIT])) else $error("save without keys");
    a_save_length: assert property ($fell(busy)
        |-> busyCnt_reg >= SAVE_LEN - 1 && busyCnt_reg <= SAVE_LEN + 1)
        else $error("programming length wrong");
endmodule : sncr_link_properties

// >>> sncr_node.sv
// stack node control register bank, device end
`timescale 1ns/1ps
module sncr_node
    import sncr_pkg::*;
#(
    parameter int WAKE_LEN = WAKE_CYCLES,
    parameter int SAVE_LEN = SAVE_CYCLES
) (
    input wire logic ref_clk,
    input wire logic rst,
    sncr_link_if.node link,
    input wire logic [4:0] gpioPins,
    input wire logic wakeDone,
    output logic frameMatch,
    output logic forwardBlock,
    output logic wakeTone,
    output logic shutdownReq,
    output logic restartReq,
    output logic nvmProgram,
    output logic [15:0] chanEnable,
    output logic [4:0] idleChannel
);
    // ==========================================
    // state
    typedef struct packed {
        logic [4:0] nodeAddress;
        logic [3:0] groupTag;
        logic [4:0] activeCellCount;
        logic addrSrcSel;
        logic assignPending;
        logic wakeActive;
        logic saveActive;
        logic shutdown;
        logic restart;
        logic [31:0] keyA;
        logic [31:0] keyB;
        logic [15:0] count;
        logic [15:0] saveCount;
        logic match;
        logic rspValid;
        logic [31:0] rspData;
        logic [15:0] chanEn;
        logic [4:0] idleCh;
        logic [4:0] gpioMeta;
        logic [4:0] gpioSync;
        logic wakeMeta;
        logic wakeSync;
    } sncr_node_t;

    sncr_node_t state_reg;
    sncr_node_t state_next;
    logic [7:0] wd;
    logic [7:0] ctrlRd;
    logic [7:0] confRd;

    always_comb begin
        state_next = state_reg;
        wd = link.reqData[7:0];
        ctrlRd = 8'h00;
        confRd = 8'h00;
        state_next.gpioMeta = gpioPins;
        state_next.gpioSync = state_reg.gpioMeta;
        state_next.wakeMeta = wakeDone;
        state_next.wakeSync = state_reg.wakeMeta;
        state_next.rspValid = 1'b0;
        state_next.restart = 1'b0;
        state_next.match = 1'b0;
        // ==========================================
        // background sequences
        if (state_reg.wakeActive) begin
            // the tone ends on the far end's report or a timeout, whichever first
            if (state_reg.wakeSync || state_reg.count == 16'(WAKE_LEN - 1)) begin
                state_next.wakeActive = 1'b0; // RQ9
            end else begin
                state_next.count = state_reg.count + 16'h0001;
            end
        end
        if (state_reg.saveActive) begin
            // the timer stands in for the memory's own completion report
            if (state_reg.saveCount == 16'(SAVE_LEN - 1)) begin
                state_next.saveActive = 1'b0; // RQ11
            end else begin
                state_next.saveCount = state_reg.saveCount + 16'h0001;
            end
        end
        // ==========================================
        // frames
        if (link.frameStrobe) begin
            if (link.frameIsGroup) begin
                state_next.match = link.frameGroup == {4'h0, state_reg.groupTag}; // RQ3
            end else begin
                state_next.match = link.frameAddr == state_reg.nodeAddress; // RQ1
            end
            if (state_reg.addrSrcSel) begin
                state_next.assignPending = 1'b0; // RQ15
            end
        end
        // ==========================================
        // read-back words; reserved and self-clearing bits stay zero
        ctrlRd[SHUTDOWN_BIT] = state_reg.shutdown; // RQ6
        ctrlRd[WAKE_BIT] = state_reg.wakeActive; // RQ9
        ctrlRd[SAVE_BIT] = state_reg.saveActive; // RQ11
        ctrlRd[ASSIGN_BIT] = state_reg.assignPending & state_reg.addrSrcSel; // RQ14
        confRd[SRC_SEL_BIT] = state_reg.addrSrcSel; // RQ21
        // ==========================================
        // register access; writes during programming are dropped as a guard
        if (link.reqValid && !state_reg.saveActive) begin
            if (link.reqWrite) begin
                unique case (link.reqAddr)
                    ADDR_OFS: begin
                        if (state_reg.assignPending) begin
                            state_next.nodeAddress = wd[4:0]; // RQ2
                        end
                    end
                    GROUP_OFS: state_next.groupTag = wd[3:0]; // RQ4
                    CONF_OFS: begin
                        state_next.addrSrcSel = wd[SRC_SEL_BIT]; // RQ21
                        // falling back to the gpio source ends any pending auto cycle
                        if (!wd[SRC_SEL_BIT]) begin
                            state_next.assignPending = 1'b0; // RQ14
                        end
                    end
                    CELL_CHANNEL_COUNT_REG_OFS: state_next.activeCellCount = wd[4:0]; // RQ16
                    // keys stay armed after a save; software rewrites them to lock again
                    KEYA_OFS: state_next.keyA = link.reqData;
                    KEYB_OFS: state_next.keyB = link.reqData;
                    CTRL_OFS: begin
                        if (wd[RESTART_BIT]) begin
                            state_next.restart = 1'b1; // RQ5
                        end
                        if (wd[SHUTDOWN_BIT]) begin
                            state_next.shutdown = 1'b1; // RQ6
                        end
                        if (wd[WAKE_BIT] && !state_reg.wakeActive) begin
                            state_next.wakeActive = 1'b1; // RQ7
                            state_next.count = 16'h0000;
                        end
                        if (wd[SAVE_BIT] && state_reg.keyA == UNLOCK_KEY_A
                                && state_reg.keyB == UNLOCK_KEY_B) begin
                            state_next.saveActive = 1'b1; // RQ10
                            state_next.saveCount = 16'h0000;
                        end
                        if (wd[ASSIGN_BIT]) begin
                            if (state_reg.addrSrcSel) begin
                                state_next.assignPending = 1'b1; // RQ15
                            end else begin
                                state_next.nodeAddress = state_reg.gpioSync; // RQ14
                            end
                        end
                    end
                    default: ;
                endcase
            end else begin
                state_next.rspValid = 1'b1;
                unique case (link.reqAddr)
                    ADDR_OFS: state_next.rspData = {27'h0, state_reg.nodeAddress}; // RQ22
                    GROUP_OFS: state_next.rspData = {28'h0, state_reg.groupTag};
                    CONF_OFS: state_next.rspData = {24'h0, confRd};
                    CELL_CHANNEL_COUNT_REG_OFS: state_next.rspData = {27'h0, state_reg.activeCellCount};
                    CTRL_OFS: state_next.rspData = {24'h0, ctrlRd}; // RQ5 RQ9 RQ11 RQ14
                    default: state_next.rspData = 32'h0;
                endcase
            end
        end
        // ==========================================
        // channel masking
        // counts above sixteen are reserved; they leave every channel enabled
        for (int i = 0; i < 16; i++) begin
            state_next.chanEn[i] = 5'(i) < state_reg.activeCellCount; // RQ16 RQ18
        end
        state_next.idleCh = (state_reg.activeCellCount == 5'h00) ? 5'h01
            : state_reg.activeCellCount; // RQ17
    end

    // ==========================================
    // registers
    always_ff @(posedge ref_clk) begin
        // a restart request also clears everything, as a fresh power-up would
        if (rst || state_reg.restart) begin
            state_reg <= '0;
            state_reg.nodeAddress <= ADDR_RESET;
            state_reg.activeCellCount <= CHAN_RESET;
            state_reg.chanEn <= 16'hffff;
            state_reg.idleCh <= CHAN_RESET;
            state_reg.restart <= rst ? 1'b0 : 1'b1; // RQ5
            if (!rst) begin
                state_reg.restart <= 1'b0;
            end
        end else begin
            state_reg <= state_next;
        end
    end

    // ==========================================
    // outputs
    assign link.rspValid = state_reg.rspValid;
    assign link.rspData = state_reg.rspData;
    assign link.busy = state_reg.saveActive;
    assign frameMatch = state_reg.match;
    assign forwardBlock = state_reg.wakeActive; // RQ8
    assign wakeTone = state_reg.wakeActive;
    assign shutdownReq = state_reg.shutdown;
    assign restartReq = state_reg.restart;
    assign nvmProgram = state_reg.saveActive;
    assign chanEnable = state_reg.chanEn;
    assign idleChannel = state_reg.idleCh;
endmodule : sncr_node

// >>> sncr_pkg.sv
// shared constants and types for the stack node control register bank
// ==========================================
// Notes on behaviour
// [RQ1] node answers frames matching five-bit address
// [RQ2] address writes only while assign trigger set
// [RQ3] group broadcast matches low nibble tag
// [RQ4] group identifier upper nibble fixed zero
// [RQ5] self-restart resets node, reads zero
// [RQ6] shutdown bit powers node down
// [RQ7] upstream wake bit sends tone upward
// [RQ8] forwarding upward blocked during wake tone
// [RQ9] wake bit reads one while tone runs
// [RQ10] save needs both unlock keys correct
// [RQ11] save bit reads one while programming; the node drops reads during programming, so it is never read as one
// [RQ12] host must not write during programming
// [RQ13] host prepares link settings before save
// [RQ14] source zero: trigger samples gpio, reads zero
// [RQ15] source one: auto mode until next frame
// [RQ16] active count drops channels from sixteen down
// [RQ17] idle channel equals count, zero gives one
// [RQ18] unused channels masked, comparators off
// [RQ19] host keeps active count at most sixteen
// [RQ20] host writes zeros to reserved bits; the host controller passes them through as the software gave them
// [RQ21] source select never changes current address
// [RQ22] reserved bits read back zero
package sncr_pkg;
    // ==========================================
    // node register map
    localparam logic [7:0] ADDR_OFS = 8'h0a;
    localparam logic [7:0] GROUP_OFS = 8'h0b;
    localparam logic [7:0] CTRL_OFS = 8'h0c;
    localparam logic [7:0] CELL_CHANNEL_COUNT_REG_OFS = 8'h0d;
    localparam logic [7:0] CONF_OFS = 8'h0e;
    localparam logic [7:0] KEYA_OFS = 8'h82;
    localparam logic [7:0] KEYB_OFS = 8'h8c;
    localparam int RESTART_BIT = 7;
    localparam int SHUTDOWN_BIT = 6;
    localparam int WAKE_BIT = 5;
    localparam int SAVE_BIT = 4;
    localparam int ASSIGN_BIT = 3;
    localparam int SRC_SEL_BIT = 4;
    localparam logic [31:0] UNLOCK_KEY_A = 32'h8c2db194;
    localparam logic [31:0] UNLOCK_KEY_B = 32'ha375e60f;
    localparam logic [4:0] ADDR_RESET = 5'h00;
    localparam logic [4:0] CHAN_RESET = 5'h10;
    localparam logic [4:0] MAX_CHAN = 5'h10;
    // ==========================================
    // timing
    localparam int WAKE_TIME_US = 10;
    localparam int SAVE_TIME_US = 100;
    localparam int CLK_MHZ = 10;
    localparam int WAKE_CYCLES = WAKE_TIME_US * CLK_MHZ;
    localparam int SAVE_CYCLES = SAVE_TIME_US * CLK_MHZ;
    // ==========================================
    // host register map over ahb-lite
    localparam logic [31:0] H_CMD_OFS = 32'h0000_0000;
    localparam logic [31:0] H_WDATA_OFS = 32'h0000_0004;
    localparam logic [31:0] H_STAT_OFS = 32'h0000_0008;
    localparam logic [31:0] H_RDATA_OFS = 32'h0000_000c;
    typedef enum logic [1:0] {SNCR_NOP, SNCR_WR, SNCR_RD, SNCR_FRAME} sncr_op_t;
endpackage : sncr_pkg

// >>> tb_top.sv
// self-checking bench: host and node joined over the link
`timescale 1ns/1ps
module tb_top;
    import sncr_pkg::*;
    // short counts keep the run brief
    localparam int SAVE_SIM = 30;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic [4:0] gpioPins = 5'h00;
    logic wakeDone = 1'b0;
    logic frameMatch;
    logic forwardBlock;
    logic wakeTone;
    logic shutdownReq;
    logic nvmProgram;
    logic [15:0] chanEnable;
    logic [4:0] idleChannel;
    int fails = 0;
    int n_tests = 0;
    int nMatch = 0;
    int nRestart = 0;
    logic restartReq;
    logic [31:0] seed = 32'hf422;
    logic [31:0] rdGot;
    logic [31:0] expQ[$];
    event rdDone;
    sncr_link_if link();
    sncr_host sncr_host_i (.ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(), .link(link));
    sncr_node #(.WAKE_LEN(40), .SAVE_LEN(SAVE_SIM)) sncr_node_i (.ref_clk(ref_clk), .rst(rst),
        .link(link), .gpioPins(gpioPins), .wakeDone(wakeDone), .frameMatch(frameMatch),
        .forwardBlock(forwardBlock), .wakeTone(wakeTone), .shutdownReq(shutdownReq),
        .restartReq(restartReq), .nvmProgram(nvmProgram), .chanEnable(chanEnable),
        .idleChannel(idleChannel));
    sncr_link_properties #(.SAVE_LEN(SAVE_SIM)) sncr_link_properties_i (.ref_clk(ref_clk),
        .rst(rst), .reqValid(link.reqValid), .reqWrite(link.reqWrite), .reqAddr(link.reqAddr),
        .reqData(link.reqData), .rspValid(link.rspValid), .rspData(link.rspData),
        .busy(link.busy));
    always #50 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (frameMatch === 1'b1) nMatch++;
    always @(posedge ref_clk) if (restartReq === 1'b1) nRestart++;
    always @(rdDone) chk(rdGot, expQ.pop_front());
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // ==========================================
    // ahb-lite single transfers, entered just after an edge
    task automatic ahb(input logic [31:0] addr, input logic wr, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= addr;
        hwrite <= wr;
        hsize <= 3'h2;
        htrans <= 2'h2;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        rdGot = hrdata;
    endtask : ahb
    task automatic cmd(input sncr_op_t op, input logic [7:0] ofs, input logic [31:0] d);
        ahb(H_WDATA_OFS, 1'b1, d);
        ahb(H_CMD_OFS, 1'b1, {22'h0, op, ofs});
        repeat (3) @(posedge ref_clk);
    endtask : cmd
    task automatic nodeRd(input logic [7:0] ofs, input logic [31:0] exp);
        expQ.push_back(exp);
        ahb(H_CMD_OFS, 1'b1, {22'h0, SNCR_RD, ofs});
        for (int w = 0; w < 20; w++) begin
            ahb(H_STAT_OFS, 1'b0, 32'h0);
            if (rdGot[1] === 1'b0) break;
        end
        ahb(H_RDATA_OFS, 1'b0, 32'h0);
        ->rdDone;
    endtask : nodeRd
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : final_report
    initial begin
        repeat (20000) @(posedge ref_clk);
        fails++;
        $display("Error at %0t: watchdog expired", $time);
        final_report();
    end
    // ==========================================
    // scenarios
    initial begin
        logic [4:0] n;
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        nodeRd(CELL_CHANNEL_COUNT_REG_OFS, 32'h10);
        chk({16'h0, chanEnable}, 32'hffff);
        $display("test reset done");
        cmd(SNCR_WR, ADDR_OFS, 32'h05);
        nodeRd(ADDR_OFS, 32'h00);
        cmd(SNCR_WR, CONF_OFS, 32'h10);
        cmd(SNCR_WR, CTRL_OFS, 32'h08);
        cmd(SNCR_WR, ADDR_OFS, 32'h05);
        nodeRd(ADDR_OFS, 32'h05);
        nodeRd(CTRL_OFS, 32'h08);
        cmd(SNCR_FRAME, 8'h00, 32'h05);
        nodeRd(CTRL_OFS, 32'h00);
        cmd(SNCR_FRAME, 8'h00, 32'h06);
        chk(32'(nMatch), 32'h1);
        cmd(SNCR_WR, GROUP_OFS, 32'hf3);
        nodeRd(GROUP_OFS, 32'h03);
        cmd(SNCR_FRAME, 8'h00, 32'h1_0300);
        cmd(SNCR_FRAME, 8'h00, 32'h1_1300);
        chk(32'(nMatch), 32'h2);
        $display("test address and group done");
        seed = lfsr(seed);
        gpioPins <= ~seed[4:0];
        cmd(SNCR_WR, CONF_OFS, 32'h00);
        nodeRd(ADDR_OFS, 32'h05);
        cmd(SNCR_WR, CTRL_OFS, 32'h08);
        nodeRd(CTRL_OFS, 32'h00);
        nodeRd(ADDR_OFS, {27'h0, ~seed[4:0]});
        $display("test gpio address done");
        for (int i = 0; i < 6; i++) begin
            seed = lfsr(seed);
            n = (i == 0) ? 5'd0 : (i == 1) ? 5'd1 : (i == 2) ? 5'd16 : 5'(seed % 17);
            cmd(SNCR_WR, CELL_CHANNEL_COUNT_REG_OFS, {27'h0, n});
            chk({16'h0, chanEnable}, (32'h1 << n) - 32'h1);
            chk({27'h0, idleChannel}, (n == 5'd0) ? 32'h1 : {27'h0, n});
        end
        $display("test channel count done");
        cmd(SNCR_WR, CTRL_OFS, 32'h20);
        chk({30'h0, wakeTone, forwardBlock}, 32'h3);
        nodeRd(CTRL_OFS, 32'h20);
        wakeDone <= 1'b1;
        for (int w = 0; w < 80 && wakeTone !== 1'b0; w++) @(posedge ref_clk);
        wakeDone <= 1'b0;
        repeat (3) @(posedge ref_clk);
        chk({30'h0, wakeTone, forwardBlock}, 32'h0);
        nodeRd(CTRL_OFS, 32'h00);
        $display("test wake done");
        cmd(SNCR_WR, KEYA_OFS, UNLOCK_KEY_A);
        cmd(SNCR_WR, KEYB_OFS, ~UNLOCK_KEY_B);
        cmd(SNCR_WR, CTRL_OFS, 32'h10);
        chk({31'h0, nvmProgram}, 32'h0);
        cmd(SNCR_WR, KEYB_OFS, UNLOCK_KEY_B);
        cmd(SNCR_WR, CTRL_OFS, 32'h10);
        chk({31'h0, nvmProgram}, 32'h1);
        cmd(SNCR_WR, GROUP_OFS, 32'h05);
        for (int w = 0; w < 200; w++) begin
            ahb(H_STAT_OFS, 1'b0, 32'h0);
            if (rdGot[0] === 1'b0) break;
        end
        nodeRd(CTRL_OFS, 32'h00);
        nodeRd(GROUP_OFS, 32'h03);
        $display("test save done");
        cmd(SNCR_WR, CTRL_OFS, 32'h40);
        chk({31'h0, shutdownReq}, 32'h1);
        cmd(SNCR_WR, CTRL_OFS, 32'h80);
        chk(32'(nRestart), 32'h1);
        chk({31'h0, shutdownReq}, 32'h0);
        nodeRd(CELL_CHANNEL_COUNT_REG_OFS, 32'h10);
        nodeRd(CTRL_OFS, 32'h00);
        $display("test shutdown and restart done");
        final_report();
    end
endmodule : tb_top
